// ===== pse_pkg.sv
package pse_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_HZ      = 40_000_000;
	localparam int unsigned STARTUP_MS  = 60;
	localparam int unsigned BACKOFF_S   = 2;
	localparam int unsigned STARTUP_CYC = STARTUP_MS * (CLK_HZ / 1000);
	localparam int unsigned BACKOFF_CYC = BACKOFF_S * CLK_HZ;
	localparam int          CNT_W       = 27;
	localparam int          NPORTS      = 4;

	// ****************************************
	// Register map and fields
	// ****************************************
	localparam logic [7:0] OFS_CFG0   = 8'h00;
	localparam logic [7:0] OFS_ICUT0  = 8'h10;
	localparam logic [7:0] OFS_CMD    = 8'h20;
	localparam logic [7:0] OFS_STAT   = 8'h24;
	localparam logic [7:0] OFS_RESULT = 8'h28;
	localparam logic [7:0] OFS_EVT    = 8'h2c;
	localparam logic [7:0] OFS_MASK   = 8'h30;
	localparam logic [7:0] OFS_DEV    = 8'h34;
	localparam int         CFG_MODE_LSB = 0;
	localparam int         CFG_EXT_BIT  = 3;
	localparam int         CMD_CODE_LSB = 2;
	localparam int         CMD_PORT_LSB = 0;
	localparam logic [7:0] CFG_RST    = 8'h04;
	localparam logic [7:0] OVERCURRENT_CUT_THRESHOLD_RST   = 8'h75;
	localparam logic [3:0] MASK_RST   = 4'hf;
	localparam logic [7:0] OVERCURRENT_CUT_THRESHOLD_CLS1  = 8'h1e;
	localparam logic [7:0] OVERCURRENT_CUT_THRESHOLD_CLS2  = 8'h35;
	localparam logic [7:0] OVERCURRENT_CUT_THRESHOLD_STD   = 8'h75;
	localparam logic [7:0] OVERCURRENT_CUT_THRESHOLD_EXT   = 8'hc9;

	// ****************************************
	// Encodings
	// ****************************************
	typedef enum logic [2:0] {
		DET_UNKNOWN = 3'b000, DET_SHORT = 3'b001, DET_RSV2 = 3'b010, DET_SIG_LOW = 3'b011,
		DET_GOOD = 3'b100, DET_HIGH = 3'b101, DET_OPEN = 3'b110, DET_RSV7 = 3'b111
	} det_t;
	typedef enum logic [2:0] {
		CLS_UNKNOWN = 3'b000, CLS_1 = 3'b001, CLS_2 = 3'b010, CLS_3 = 3'b011,
		CLS_4 = 3'b100, CLS_PNE = 3'b101, CLS_0 = 3'b110, CLS_OVL = 3'b111
	} cls_t;
	typedef enum logic [1:0] {
		MODE_SHUT = 2'b00, MODE_MANUAL = 2'b01, MODE_SEMI = 2'b10, MODE_AUTO = 2'b11
	} mode_t;
	typedef enum logic [2:0] {
		CMD_NONE = 3'b000, CMD_PWR_ON = 3'b001, CMD_PWR_OFF = 3'b010, CMD_RST_PORT = 3'b011,
		CMD_BACKOFF = 3'b100, CMD_RST_CHIP = 3'b101, CMD_GET_VEE = 3'b110, CMD_GET_CUR = 3'b111
	} cmd_t;
	typedef enum logic [2:0] {
		P_IDLE = 3'b000, P_DET = 3'b001, P_CLS1 = 3'b010, P_CLS2 = 3'b011,
		P_PEND = 3'b100, P_START = 3'b101, P_ON = 3'b110
	} pstate_t;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [NPORTS-1:0]        det_done;
		logic [NPORTS-1:0]        cls_done;
		det_t [NPORTS-1:0]        det_res;
		cls_t [NPORTS-1:0]        cls_res;
		logic [15:0]              vee_mv;
		logic [NPORTS-1:0][15:0]  cur;
	} afe_in_t;
	typedef struct packed {
		logic [NPORTS-1:0]        det_start;
		logic [NPORTS-1:0]        cls_start;
		logic [NPORTS-1:0]        pwr_en;
		logic [NPORTS-1:0]        current_limit_high;
		logic [NPORTS-1:0][7:0]   overcurrent_cut_threshold;
	} afe_out_t;

endpackage

// ===== pse_port_command_control.sv
// Chosen here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
// Contract
// - Detection result codes: unknown, short, low, good, high, open; 010/111 reserved.
// - Class codes: unknown, 1-4, probes unequal, 110 class 0, 111 overload.
// - Port mode 00 shutdown, 01 manual, 10 semi-automatic, 11 automatic.
// - Automatic mode, class 1 loads threshold 0x1E regardless of extended power.
// - Automatic mode, class 2 loads threshold 0x35 regardless of extended power.
// - Automatic mode, class 0/3, or class 4 without extended power, loads 0x75.
// - Automatic mode, class 4 with extended power loads 0xC9, limit 850 mA.
// - First 60 ms after turn-on the limit stays at 425 mA.
// - Command byte: code in bits 4:2, port in 1:0; 001 on, 010 off, 011 reset.
// - Code 100 toggles the detection back-off bit.
// - With back-off set, wait 2 s between detection attempts.
// - Code 101 resets the whole chip.
// - Code 110 returns supply voltage in millivolts, two bytes.
// - Code 111 returns selected port current in 100 uA units, two bytes.
// - Automatic mode sequences power-up, second class event on class 4 with extension.
// - Semi-automatic raises class-complete event after good detection and class result.
// - Manual power-on skips detection, classifies, refuses invalid class signature.
// - Manual power-on refuses overload, or second event not class 4.
// - Manual power-on classification does not set class-complete event.
// - Power-on command in semi or automatic mode still powers the port.
// - Event register and interrupt pin always agree, within 5 ms.
module pse_port_command_control
	import pse_pkg::*;
#(
	parameter int unsigned STARTUP_CYCLES = STARTUP_CYC,
	parameter int unsigned BACKOFF_CYCLES = BACKOFF_CYC
)
(
	input  wire logic        MCLK,
	input  wire logic        RST_N,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic             HREADYOUT,
	output logic [31:0]      HRDATA,
	output logic             HRESP,
	input  wire afe_in_t     AFE_IN,
	output afe_out_t         AFE_OUT,
	output logic             INT_N
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		pstate_t           st;
		logic [CNT_W-1:0]  cnt;
		det_t              det;
		cls_t              cls;
		logic              manual;
		logic              two;
		logic              current_limit_hi;
		logic              dstart;
		logic              cstart;
	} port_t;

	typedef struct packed {
		port_t [NPORTS-1:0]       port;
		logic [NPORTS-1:0][7:0]   cfg;
		logic [NPORTS-1:0][7:0]   overcurrent_cut_threshold;
		logic                     backoff;
		logic [15:0]              result;
		logic [NPORTS-1:0]        evt;
		logic [NPORTS-1:0]        mask;
		logic                     int_n;
		logic                     bus_sel;
		logic                     bus_wr;
		logic [7:0]               bus_addr;
		logic [31:0]              rdata;
	} state_t;

	state_t      s_q;
	state_t      s_d;
	logic        cmd_we;
	cmd_t        cmd_code;
	logic [1:0]  cmd_port;

	function automatic state_t rst_state();
		state_t r;
		r = '0;
		r.cfg = {NPORTS{CFG_RST}};
		r.overcurrent_cut_threshold = {NPORTS{OVERCURRENT_CUT_THRESHOLD_RST}};
		r.mask = MASK_RST;
		r.int_n = 1'b1;
		return r;
	endfunction

	function automatic logic [7:0] overcurrent_cut_threshold_for(cls_t c, logic ext);
		case (c)
			CLS_1:   overcurrent_cut_threshold_for = OVERCURRENT_CUT_THRESHOLD_CLS1;
			CLS_2:   overcurrent_cut_threshold_for = OVERCURRENT_CUT_THRESHOLD_CLS2;
			CLS_4:   overcurrent_cut_threshold_for = ext ? OVERCURRENT_CUT_THRESHOLD_EXT : OVERCURRENT_CUT_THRESHOLD_STD;
			default: overcurrent_cut_threshold_for = OVERCURRENT_CUT_THRESHOLD_STD;
		endcase
	endfunction

	// Classes that carry a usable power signature
	function automatic logic cls_ok(cls_t c);
		cls_ok = (c != CLS_UNKNOWN) && (c != CLS_PNE) && (c != CLS_OVL);
	endfunction

	// ****************************************
	// Command decode
	// ****************************************
	always_comb
	begin
		cmd_we = s_q.bus_sel && s_q.bus_wr && (s_q.bus_addr == OFS_CMD);
		cmd_code = cmd_t'(HWDATA[CMD_CODE_LSB +: 3]);
		cmd_port = HWDATA[CMD_PORT_LSB +: 2];
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		logic [31:0]        rd;
		logic [NPORTS-1:0]  set_evt;
		logic [NPORTS-1:0]  clr_evt;
		logic [CNT_W-1:0]   wait_cnt;
		mode_t              mode;
		logic               ext;
		logic               fin;
		logic               ok;
		cls_t               res;
		state_t             r;
		rd = '0;
		set_evt = '0;
		clr_evt = '0;
		mode = MODE_SHUT;
		ext = 1'b0;
		fin = 1'b0;
		ok = 1'b0;
		res = CLS_UNKNOWN;
		r = '0;
		s_d = s_q;
		// Back-off wait is loaded on failed detection, on a class finish that does not power up, and on power-off or port reset
		wait_cnt = s_q.backoff ? CNT_W'(BACKOFF_CYCLES) : '0;

		// Address phase: latch and prepare read data so HRDATA comes from a flop
		s_d.bus_sel = HSEL && HTRANS[1] && HREADY;
		s_d.bus_wr = HWRITE;
		s_d.bus_addr = HADDR[7:0];
		if (HSEL && HTRANS[1] && HREADY && !HWRITE)
		begin
			if (HADDR[7:4] == OFS_CFG0[7:4])
				rd = {24'h000000, s_q.cfg[HADDR[3:2]]};
			else if (HADDR[7:4] == OFS_ICUT0[7:4])
				rd = {24'h000000, s_q.overcurrent_cut_threshold[HADDR[3:2]]};
			else
			begin
				case (HADDR[7:0])
					OFS_STAT:
						for (int p = 0; p < NPORTS; p++)
							rd[8*p +: 8] = {s_q.port[p].st == P_ON,
								(s_q.port[p].st == P_START) || (s_q.port[p].st == P_ON),
								s_q.port[p].cls, s_q.port[p].det};
					OFS_RESULT: rd = {16'h0000, s_q.result};
					OFS_EVT:
					begin
						rd = {28'h0000000, s_q.evt};
						// Clear on read; a set in the same cycle survives
						clr_evt = '1;
					end
					OFS_MASK: rd = {28'h0000000, s_q.mask};
					OFS_DEV:  rd = {31'h00000000, s_q.backoff};
					default:  rd = '0;
				endcase
			end
		end
		// Read data stands until the next read is taken, so the data phase edge is race free
		if (HSEL && HTRANS[1] && HREADY && !HWRITE)
			s_d.rdata = rd;

		// Data phase writes
		if (s_q.bus_sel && s_q.bus_wr)
		begin
			if (s_q.bus_addr[7:4] == OFS_CFG0[7:4])
				s_d.cfg[s_q.bus_addr[3:2]] = {4'h0, HWDATA[3:0]};
			else if (s_q.bus_addr[7:4] == OFS_ICUT0[7:4])
				s_d.overcurrent_cut_threshold[s_q.bus_addr[3:2]] = HWDATA[7:0];
			else if (s_q.bus_addr == OFS_MASK)
				s_d.mask = HWDATA[NPORTS-1:0];
		end
		if (cmd_we && cmd_code == CMD_BACKOFF)
			s_d.backoff = !s_q.backoff;
		if (cmd_we && cmd_code == CMD_GET_VEE)
			s_d.result = AFE_IN.vee_mv;
		if (cmd_we && cmd_code == CMD_GET_CUR)
			s_d.result = AFE_IN.cur[cmd_port];

		// Per-port sequencing
		for (int i = 0; i < NPORTS; i++)
		begin
			mode = mode_t'(s_q.cfg[i][CFG_MODE_LSB +: 2]);
			ext = s_q.cfg[i][CFG_EXT_BIT];
			fin = 1'b0;
			res = AFE_IN.cls_res[i];
			s_d.port[i].dstart = 1'b0;
			s_d.port[i].cstart = 1'b0;
			if (s_q.port[i].cnt != '0)
				s_d.port[i].cnt = s_q.port[i].cnt - 1'b1;
			case (s_q.port[i].st)
				P_IDLE:
					if ((mode == MODE_SEMI || mode == MODE_AUTO) && s_q.port[i].cnt == '0)
					begin
						s_d.port[i].st = P_DET;
						s_d.port[i].dstart = 1'b1;
					end
				P_DET:
					if (AFE_IN.det_done[i])
					begin
						s_d.port[i].det = AFE_IN.det_res[i];
						if (AFE_IN.det_res[i] == DET_GOOD)
						begin
							s_d.port[i].st = P_CLS1;
							s_d.port[i].cstart = 1'b1;
							s_d.port[i].manual = 1'b0;
						end
						else
						begin
							s_d.port[i].st = P_IDLE;
							s_d.port[i].cnt = wait_cnt;
						end
					end
				P_CLS1:
					if (AFE_IN.cls_done[i])
					begin
						s_d.port[i].cls = res;
						s_d.port[i].two = 1'b0;
						if (res == CLS_4 && ext)
						begin
							// Second classification event
							s_d.port[i].st = P_CLS2;
							s_d.port[i].cstart = 1'b1;
						end
						else
							fin = 1'b1;
					end
				P_CLS2:
					if (AFE_IN.cls_done[i])
					begin
						s_d.port[i].cls = res;
						s_d.port[i].two = 1'b1;
						fin = 1'b1;
					end
				P_PEND:
					if (mode != MODE_SEMI && mode != MODE_MANUAL)
						s_d.port[i].st = P_IDLE;
				P_START:
					// Limit stays low until the start-up interval runs out
					if (s_q.port[i].cnt == '0)
					begin
						s_d.port[i].st = P_ON;
						s_d.port[i].current_limit_hi = ext && (s_q.port[i].cls == CLS_4);
					end
				P_ON:
					s_d.port[i].st = P_ON;
				default:
					s_d.port[i].st = P_IDLE;
			endcase

			if (fin)
			begin
				ok = cls_ok(res) && !(s_d.port[i].two && res != CLS_4);
				if (s_q.port[i].manual)
				begin
					// No class-complete event on this path
					s_d.port[i].st = ok ? P_START : P_IDLE;
				end
				else if (mode == MODE_AUTO)
				begin
					s_d.overcurrent_cut_threshold[i] = overcurrent_cut_threshold_for(res, ext);
					s_d.port[i].st = ok ? P_START : P_IDLE;
				end
				else
				begin
					set_evt[i] = 1'b1;
					s_d.port[i].st = P_PEND;
				end
				s_d.port[i].cnt = (s_d.port[i].st == P_START) ? CNT_W'(STARTUP_CYCLES) : wait_cnt;
				s_d.port[i].current_limit_hi = 1'b0;
			end

			if (mode == MODE_SHUT)
			begin
				s_d.port[i].st = P_IDLE;
				s_d.port[i].current_limit_hi = 1'b0;
			end
			else if (cmd_we && cmd_port == i[1:0])
			begin
				case (cmd_code)
					CMD_PWR_ON:
					begin
						// Honoured in every active mode, detection skipped
						s_d.port[i].st = P_CLS1;
						s_d.port[i].cstart = 1'b1;
						s_d.port[i].manual = 1'b1;
						s_d.port[i].current_limit_hi = 1'b0;
					end
					CMD_PWR_OFF, CMD_RST_PORT:
					begin
						s_d.port[i].st = P_IDLE;
						s_d.port[i].manual = 1'b0;
						s_d.port[i].current_limit_hi = 1'b0;
						s_d.port[i].cnt = wait_cnt;
						if (cmd_code == CMD_RST_PORT)
						begin
							s_d.port[i].det = DET_UNKNOWN;
							s_d.port[i].cls = CLS_UNKNOWN;
						end
					end
					default:
						s_d.port[i].st = s_d.port[i].st;
				endcase
			end
		end

		// Set wins over clear-on-read; pin follows register in the same cycle
		s_d.evt = (s_q.evt & ~clr_evt) | set_evt;
		s_d.int_n = !(|(s_d.evt & s_d.mask));

		if (cmd_we && cmd_code == CMD_RST_CHIP)
		begin
			// Bus phase state survives so the current transfer completes
			r = rst_state();
			r.bus_sel = s_d.bus_sel;
			r.bus_wr = s_d.bus_wr;
			r.bus_addr = s_d.bus_addr;
			r.rdata = s_d.rdata;
			s_d = r;
		end
	end

	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
			s_q <= rst_state();
		else
			s_q <= s_d;
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_comb
	begin
		HREADYOUT = 1'b1;
		HRESP = 1'b0;
		HRDATA = s_q.rdata;
		INT_N = s_q.int_n;
		AFE_OUT.overcurrent_cut_threshold = s_q.overcurrent_cut_threshold;
		for (int i = 0; i < NPORTS; i++)
		begin
			AFE_OUT.det_start[i] = s_q.port[i].dstart;
			AFE_OUT.cls_start[i] = s_q.port[i].cstart;
			AFE_OUT.pwr_en[i] = (s_q.port[i].st == P_START) || (s_q.port[i].st == P_ON);
			AFE_OUT.current_limit_high[i] = s_q.port[i].current_limit_hi;
		end
	end

	// ****************************************
	// Assertions (ports the scenarios exercise)
	// ****************************************
	startup_limit_a: assert property (@(posedge MCLK) disable iff (!RST_N)
		(s_q.port[0].st == P_START) |-> !AFE_OUT.current_limit_high[0] && AFE_OUT.pwr_en[0])
		else $error("limit raised during start-up");

	class1_overcurrent_cut_threshold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
		(s_q.port[0].st == P_CLS1 && AFE_IN.cls_done[0] && AFE_IN.cls_res[0] == CLS_1
		&& s_q.cfg[0][1:0] == MODE_AUTO && !s_q.port[0].manual && !cmd_we)
		|=> s_q.overcurrent_cut_threshold[0] == 8'h1e && s_q.port[0].st == P_START)
		else $error("class 1 threshold not loaded");

	ext4_overcurrent_cut_threshold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
		(s_q.port[0].st == P_CLS2 && AFE_IN.cls_done[0] && AFE_IN.cls_res[0] == CLS_4
		&& s_q.cfg[0][1:0] == MODE_AUTO && !s_q.port[0].manual && !cmd_we)
		|=> s_q.overcurrent_cut_threshold[0] == 8'hc9)
		else $error("extended threshold not loaded");

	overload_refuse_a: assert property (@(posedge MCLK) disable iff (!RST_N)
		(s_q.port[2].st == P_CLS1 && s_q.port[2].manual && AFE_IN.cls_done[2]
		&& AFE_IN.cls_res[2] == CLS_OVL && !cmd_we)
		|=> !AFE_OUT.pwr_en[2] ##1 !AFE_OUT.pwr_en[2])
		else $error("overload port powered");

	semi_event_a: assert property (@(posedge MCLK) disable iff (!RST_N)
		(s_q.port[1].st == P_CLS1 && AFE_IN.cls_done[1] && AFE_IN.cls_res[1] == CLS_2
		&& s_q.cfg[1][1:0] == MODE_SEMI && !s_q.port[1].manual && !cmd_we)
		|=> s_q.evt[1] && s_q.port[1].st == P_PEND)
		else $error("class-complete event missing");

	manual_noevt_a: assert property (@(posedge MCLK) disable iff (!RST_N)
		(s_q.port[2].st == P_CLS1 && s_q.port[2].manual && !s_q.evt[2])
		|=> !s_q.evt[2])
		else $error("manual classification set event");

	int_agree_a: assert property (@(posedge MCLK) disable iff (!RST_N)
		INT_N == !(|(s_q.evt & s_q.mask)))
		else $error("interrupt pin disagrees with register");

	backoff_toggle_a: assert property (@(posedge MCLK) disable iff (!RST_N)
		(cmd_we && cmd_code == CMD_BACKOFF) |=> s_q.backoff != $past(s_q.backoff))
		else $error("back-off bit not toggled");

	manual_skip_a: assert property (@(posedge MCLK) disable iff (!RST_N)
		(cmd_we && cmd_code == CMD_PWR_ON && cmd_port == 2'b10 && s_q.cfg[2][1:0] != MODE_SHUT)
		|=> s_q.port[2].st == P_CLS1 && AFE_OUT.cls_start[2] && !AFE_OUT.det_start[2])
		else $error("power-on did not go straight to classification");

endmodule

// ===== pse_afe_model.sv
`timescale 1ns/1ps
module pse_afe_model
	import pse_pkg::*;
#(
	parameter logic [15:0] VEE_MV = 16'hbb80,
	parameter logic [15:0] CUR0   = 16'h0123
)
(
	input  wire logic                   mclk,
	input  wire logic                   rst_n,
	input  wire logic                   slow,
	input  wire logic [NPORTS-1:0][2:0] det_code,
	input  wire logic [NPORTS-1:0][2:0] cls_a,
	input  wire logic [NPORTS-1:0][2:0] cls_b,
	input  wire afe_out_t               afe_out,
	output afe_in_t                     afe_in
);
	logic [NPORTS-1:0]      det_busy;
	logic [NPORTS-1:0]      cls_busy;
	logic [NPORTS-1:0]      second;
	logic [NPORTS-1:0][3:0] cnt;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			det_busy <= '0;
			cls_busy <= '0;
			second <= '0;
			cnt <= '0;
			afe_in <= '0;
		end
		else
		begin
			afe_in.vee_mv <= VEE_MV;
			for (int p = 0; p < NPORTS; p++)
			begin
				afe_in.cur[p] <= CUR0 + 16'(p);
				afe_in.det_done[p] <= 1'b0;
				afe_in.cls_done[p] <= 1'b0;
				// Results mean nothing off the pulse, so keep them churning
				afe_in.det_res[p] <= det_t'(~afe_in.det_res[p]);
				afe_in.cls_res[p] <= cls_t'(~afe_in.cls_res[p]);
				if (afe_out.det_start[p])
				begin
					det_busy[p] <= 1'b1;
					second[p] <= 1'b0;
					cnt[p] <= slow ? 4'h9 : 4'h2;
				end
				else if (afe_out.cls_start[p])
				begin
					cls_busy[p] <= 1'b1;
					cnt[p] <= slow ? 4'h9 : 4'h2;
				end
				else if (cnt[p] != 4'h0)
					cnt[p] <= cnt[p] - 4'h1;
				else if (det_busy[p])
				begin
					det_busy[p] <= 1'b0;
					afe_in.det_done[p] <= 1'b1;
					afe_in.det_res[p] <= det_t'(det_code[p]);
				end
				else if (cls_busy[p])
				begin
					cls_busy[p] <= 1'b0;
					// Second event only follows a first class 4 result
					second[p] <= !second[p] && (cls_a[p] == 3'(CLS_4));
					afe_in.cls_done[p] <= 1'b1;
					afe_in.cls_res[p] <= cls_t'(second[p] ? cls_b[p] : cls_a[p]);
				end
			end
		end
	end
endmodule

// ===== pse_port_command_control_bench.sv
`timescale 1ns/1ps
module pse_port_command_control_bench;
	import pse_pkg::*;
	localparam logic [15:0] VEE = 16'hbb80;
	localparam logic [15:0] CUR = 16'h0123;
	logic                   mclk = 0;
	logic                   rst_n = 0;
	logic                   hsel = 0;
	logic                   hwrite = 0;
	logic                   slow = 0;
	logic [1:0]             htrans = 0;
	logic [31:0]            haddr = 0;
	logic [31:0]            hwdata = 0;
	logic [31:0]            rd;
	logic [31:0]            q;
	logic                   hready;
	logic                   hresp;
	logic                   int_n;
	afe_in_t                afe_in;
	afe_out_t               afe_out;
	logic [NPORTS-1:0][2:0] det_code = {4{DET_GOOD}};
	logic [NPORTS-1:0][2:0] cls_a = {4{CLS_1}};
	logic [NPORTS-1:0][2:0] cls_b = {4{CLS_4}};
	int                     err_count = 0;
	int                     checks = 0;
	int                     cyc = 0;
	int                     last = 0;
	int                     gap = 0;
	int                     dets = 0;
	logic [2:0] tc_cls[6] = '{CLS_1, CLS_2, CLS_0, CLS_3, CLS_4, CLS_4};
	logic       tc_ext[6] = '{1, 1, 0, 1, 0, 1};
	logic [7:0] tc_overcurrent_cut_threshold[6] = '{OVERCURRENT_CUT_THRESHOLD_CLS1, OVERCURRENT_CUT_THRESHOLD_CLS2, OVERCURRENT_CUT_THRESHOLD_STD, OVERCURRENT_CUT_THRESHOLD_STD, OVERCURRENT_CUT_THRESHOLD_STD, OVERCURRENT_CUT_THRESHOLD_EXT};
	logic [2:0] m_a[6] = '{CLS_OVL, CLS_PNE, CLS_4, CLS_UNKNOWN, CLS_4, CLS_3};
	logic [2:0] m_b[6] = '{CLS_4, CLS_4, CLS_2, CLS_4, CLS_4, CLS_4};
	logic       m_ext[6] = '{0, 0, 1, 0, 1, 0};
	logic       m_on[6] = '{0, 0, 0, 0, 1, 1};
	logic [2:0] bad_det[4] = '{DET_SHORT, DET_SIG_LOW, DET_HIGH, DET_OPEN};

	pse_port_command_control #(.STARTUP_CYCLES(20), .BACKOFF_CYCLES(30)) u_pse_port_command_control (
		.MCLK(mclk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
		.HREADYOUT(hready), .HRDATA(rd), .HRESP(hresp), .AFE_IN(afe_in),
		.AFE_OUT(afe_out), .INT_N(int_n));
	pse_afe_model #(.VEE_MV(VEE), .CUR0(CUR)) u_pse_afe_model (.mclk(mclk), .rst_n(rst_n),
		.slow(slow), .det_code(det_code), .cls_a(cls_a), .cls_b(cls_b), .afe_out(afe_out),
		.afe_in(afe_in));

	initial
	begin
		forever #12.5 mclk = ~mclk;
	end

	// Detection spacing on port 3, detection starts on port 2
	always @(posedge mclk)
	begin
		cyc++;
		if (afe_out.det_start[3] === 1'b1)
		begin
			gap = cyc - last;
			last = cyc;
		end
		if (afe_out.det_start[2] === 1'b1)
			dets++;
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic tally_and_finish(input bit hung);
		if (hung)
			err_count++;
		if (err_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic sig(input int k, input int p);
		return (k == 0) ? afe_out.pwr_en[p] : int_n;
	endfunction

	// Bounded wait for a port's power or the interrupt pin
	task automatic wait_for(input int k, input int p, input logic v);
		for (int n = 0; sig(k, p) !== v; n++)
		begin
			if (n > 300)
				tally_and_finish(1);
			@(posedge mclk);
		end
	endtask

	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge mclk);
		while (hready !== 1'b1)
		begin
			if (++n > 50)
				tally_and_finish(1);
			@(posedge mclk);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = rd;
	endtask

	// Extra edge so a command's result has landed before the next access
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		@(posedge mclk);
	endtask

	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		cmp(what, exp, q);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	initial
	begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		cmp("int_n", 1, int_n);
		rdc("cfg0", OFS_CFG0, CFG_RST);
		for (int p = 0; p < NPORTS; p++)
			rdc("overcurrent_cut_threshold", OFS_ICUT0 + 8'(4 * p), OVERCURRENT_CUT_THRESHOLD_RST);
		rdc("mask", OFS_MASK, MASK_RST);
		rdc("cmd", OFS_CMD, 0);
		rdc("unmapped", 8'hfc, 0);
		wr(OFS_CMD, {CMD_PWR_ON, 2'd0});
		repeat (20) @(posedge mclk);
		cmp("shut pwr", 0, afe_out.pwr_en[0]);
		wr(OFS_CFG0, {MODE_AUTO});
		for (int i = 0; i < 4; i++)
		begin
			det_code[0] <= bad_det[i];
			repeat (25) @(posedge mclk);
			bus(1'b0, OFS_STAT, 32'h0);
			cmp("det", bad_det[i], q[2:0]);
			cmp("det pwr", 0, afe_out.pwr_en[0]);
		end
		wr(OFS_CFG0, CFG_RST);
		det_code[0] <= DET_GOOD;
		for (int i = 0; i < 6; i++)
		begin
			cls_a[0] <= tc_cls[i];
			slow <= i[0];
			wr(OFS_ICUT0, 0);
			wr(OFS_CFG0, {tc_ext[i], 1'b1, MODE_AUTO});
			wait_for(0, 0, 1);
			cmp("overcurrent_cut_threshold", tc_overcurrent_cut_threshold[i], afe_out.overcurrent_cut_threshold[0]);
			cmp("current_limit start", 0, afe_out.current_limit_high[0]);
			repeat (25) @(posedge mclk);
			cmp("current_limit", tc_ext[i] & (tc_cls[i] == CLS_4), afe_out.current_limit_high[0]);
			wr(OFS_CFG0, CFG_RST);
			wait_for(0, 0, 0);
		end
		cls_a[1] <= CLS_2;
		wr(OFS_CFG0 + 8'h4, {MODE_SEMI});
		wait_for(1, 0, 0);
		wr(OFS_MASK, 0);
		repeat (2) @(posedge mclk);
		cmp("int masked", 1, int_n);
		wr(OFS_MASK, MASK_RST);
		repeat (2) @(posedge mclk);
		cmp("int unmasked", 0, int_n);
		rdc("evt", OFS_EVT, 32'h2);
		repeat (2) @(posedge mclk);
		cmp("int cleared", 1, int_n);
		wr(OFS_CMD, {CMD_PWR_ON, 2'd1});
		wait_for(0, 1, 1);
		rdc("evt", OFS_EVT, 0);
		wr(OFS_CMD, {CMD_PWR_OFF, 2'd1});
		wait_for(0, 1, 0);
		wr(OFS_CFG0 + 8'h4, CFG_RST);
		for (int i = 0; i < 6; i++)
		begin
			cls_a[2] <= m_a[i];
			cls_b[2] <= m_b[i];
			slow <= i[0];
			wr(OFS_CFG0 + 8'h8, {m_ext[i], 1'b1, MODE_MANUAL});
			dets = 0;
			wr(OFS_CMD, {CMD_PWR_ON, 2'd2});
			repeat (40) @(posedge mclk);
			cmp("manual pwr", m_on[i], afe_out.pwr_en[2]);
			cmp("no detect", 0, dets);
			wr(OFS_CMD, {CMD_RST_PORT, 2'd2});
			wait_for(0, 2, 0);
		end
		wr(OFS_CMD, {CMD_GET_VEE, 2'd0});
		rdc("vee", OFS_RESULT, VEE);
		for (int p = 0; p < NPORTS; p++)
		begin
			wr(OFS_CMD, {CMD_GET_CUR, 2'(p)});
			rdc("cur", OFS_RESULT, CUR + 16'(p));
		end
		det_code[3] <= DET_OPEN;
		slow <= 1'b0;
		rdc("backoff", OFS_DEV, 0);
		wr(OFS_CMD, {CMD_BACKOFF, 2'd0});
		rdc("backoff", OFS_DEV, 1);
		wr(OFS_CFG0 + 8'hc, {MODE_AUTO});
		repeat (200) @(posedge mclk);
		cmp("slow gap", 1, gap >= 30);
		wr(OFS_CMD, {CMD_BACKOFF, 2'd0});
		rdc("backoff", OFS_DEV, 0);
		repeat (100) @(posedge mclk);
		cmp("fast gap", 1, gap < 30);
		wr(OFS_CMD, {CMD_BACKOFF, 2'd0});
		wr(OFS_ICUT0 + 8'h4, 8'h12);
		wr(OFS_MASK, 3);
		wr(OFS_CMD, {CMD_RST_CHIP, 2'd0});
		rdc("icut1", OFS_ICUT0 + 8'h4, OVERCURRENT_CUT_THRESHOLD_RST);
		rdc("mask", OFS_MASK, MASK_RST);
		rdc("backoff", OFS_DEV, 0);
		rdc("cfg3", OFS_CFG0 + 8'hc, CFG_RST);
		tally_and_finish(0);
	end
endmodule
